/* design/pfb_flag_bank.sv */
// Permanent fail flag bank with pack condition word behind an APB slave
`timescale 1ns/1ps

module pfb_flag_bank #(
	parameter int SEC_CYC = pfb_pkg::SEC_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] stat_b_cond,
	input wire logic [7:0] alert_c_cond,
	input wire logic [7:0] stat_c_cond,
	input wire logic alert_d_cond,
	input wire logic stat_d_cond,
	input wire logic host_forced_fail,
	input wire logic safety_fault_active,
	input wire logic sleep_state,
	input wire logic shutdown_cmd,
	input wire logic shutdown_pin,
	input wire logic fuse_pin,
	input wire logic [1:0] security_state,
	input wire logic [6:4] low_flags,
	input wire logic sleep_allowed,
	input wire logic soft_charge_state,
	input wire logic enter_config_edit_command,
	input wire logic exit_config_edit_command,
	output logic config_edit_state,
	output logic irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] stat_b_ff, alert_c_ff, stat_c_ff;
	logic alert_d_ff, stat_d_ff;
	logic [16:0] en_ff;
	logic [15:0] pack_ff, nxt_pack;
	logic [2:0] int_stat_ff, int_mask_ff, nxt_int_ev;
	logic [2:0] shut_sync_ff, fuse_sync_ff;
	logic shut_flt_ff, fuse_flt_ff, fuse_smp_ff;
	logic sdp_ff, por_ff;
	logic [31:0] sec_cnt_ff, hold_cnt_ff;
	pfb_pkg::pfb_cfg_t cfg_ff;
	logic setup_ph, wr_acc, rd_set;
	logic [7:0] nxt_alert_c;
	logic nxt_pf_sum;

	// Mapped address check, shared by read and write paths
	function automatic logic pfb_mapped(input logic [7:0] a);
		pfb_mapped = (a == pfb_pkg::OFS_STAT_B) ||
			(a == pfb_pkg::OFS_ALRT_C) || (a == pfb_pkg::OFS_STAT_C) ||
			(a == pfb_pkg::OFS_ALRT_D) || (a == pfb_pkg::OFS_STAT_D) ||
			(a == pfb_pkg::OFS_PACK) || (a == pfb_pkg::OFS_PF_EN) ||
			(a == pfb_pkg::OFS_INT_STAT) || (a == pfb_pkg::OFS_INT_MASK);
	endfunction

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// Zero wait states; read data captured in the setup phase
	assign pready = 1'b1;
	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite && pfb_mapped(paddr);
	assign rd_set = setup_ph && !pwrite;
	// Read data and error registered at setup, stable in access
	// read is pure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			pslverr <= !pfb_mapped(paddr);
			prdata <= 32'h0000_0000;
			if (!pwrite) begin
				if (paddr == pfb_pkg::OFS_STAT_B) begin
					prdata[7:0] <= stat_b_ff;
				end else if (paddr == pfb_pkg::OFS_ALRT_C) begin
					prdata[7:0] <= alert_c_ff;
				end else if (paddr == pfb_pkg::OFS_STAT_C) begin
					prdata[7:0] <= stat_c_ff;
				end else if (paddr == pfb_pkg::OFS_ALRT_D) begin
					prdata[0] <= alert_d_ff;
				end else if (paddr == pfb_pkg::OFS_STAT_D) begin
					prdata[0] <= stat_d_ff;
				end else if (paddr == pfb_pkg::OFS_PACK) begin
					prdata[15:0] <= pack_ff;
				end else if (paddr == pfb_pkg::OFS_PF_EN) begin
					prdata[16:0] <= en_ff;
				end else if (paddr == pfb_pkg::OFS_INT_STAT) begin
					prdata[2:0] <= int_stat_ff;
				end else if (paddr == pfb_pkg::OFS_INT_MASK) begin
					prdata[2:0] <= int_mask_ff;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Enables, writable only while configuration editing is open
	// ----------------------------------------------------------------
	// edits gated
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff <= pfb_pkg::EN_RST;
		end else if (wr_acc && paddr == pfb_pkg::OFS_PF_EN &&
			config_edit_state) begin
			en_ff <= pwdata[16:0];
		end
	end

	// ----------------------------------------------------------------
	// Permanent fail status flags, latched until reset
	// ----------------------------------------------------------------
	// latch status B
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_b_ff <= 8'h00;
		end else begin
			stat_b_ff <= stat_b_ff | (stat_b_cond & pfb_pkg::MSK_STAT_B &
				en_ff[pfb_pkg::EN_B_LSB +: 8]);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_c_ff <= 8'h00;
		end else begin
			stat_c_ff <= stat_c_ff | ((stat_c_cond |
				{host_forced_fail, 7'h00}) & pfb_pkg::MSK_STAT_C &
				en_ff[pfb_pkg::EN_C_LSB +: 8]);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_d_ff <= 1'b0;
			alert_d_ff <= 1'b0;
		end else begin
			stat_d_ff <= stat_d_ff | (stat_d_cond & en_ff[pfb_pkg::EN_D_BIT]);
			alert_d_ff <= alert_d_cond & en_ff[pfb_pkg::EN_D_BIT];
		end
	end
	assign nxt_alert_c = alert_c_cond & pfb_pkg::MSK_ALRT_C &
		en_ff[pfb_pkg::EN_C_LSB +: 8];
	// Alert flags follow the condition while it lasts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_c_ff <= 8'h00;
		end else begin
			alert_c_ff <= nxt_alert_c;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers: three stages, change taken when 2 and 3 agree
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shut_sync_ff <= 3'h0;
			fuse_sync_ff <= 3'h0;
			shut_flt_ff <= 1'b0;
			fuse_flt_ff <= 1'b0;
		end else begin
			shut_sync_ff <= {shut_sync_ff[1:0], shutdown_pin};
			fuse_sync_ff <= {fuse_sync_ff[1:0], fuse_pin};
			if (shut_sync_ff[1] == shut_sync_ff[2]) begin
				shut_flt_ff <= shut_sync_ff[2];
			end
			if (fuse_sync_ff[1] == fuse_sync_ff[2]) begin
				fuse_flt_ff <= fuse_sync_ff[2];
			end
		end
	end

	// ----------------------------------------------------------------
	// One second timers
	// ----------------------------------------------------------------
	// fuse sampled once a second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_cnt_ff <= 32'h0000_0000;
			fuse_smp_ff <= 1'b0;
		end else if (sec_cnt_ff == 32'(SEC_CYC - 1)) begin
			sec_cnt_ff <= 32'h0000_0000;
			fuse_smp_ff <= fuse_flt_ff;
		end else begin
			sec_cnt_ff <= sec_cnt_ff + 32'h0000_0001;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt_ff <= 32'h0000_0000;
		end else if (!shut_flt_ff) begin
			hold_cnt_ff <= 32'h0000_0000;
		end else if (hold_cnt_ff != 32'(SEC_CYC)) begin
			hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdp_ff <= 1'b0;
		end else if (shutdown_cmd || hold_cnt_ff == 32'(SEC_CYC)) begin
			sdp_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Configuration edit sequence
	// ----------------------------------------------------------------
	// set after processing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= pfb_pkg::PFB_CFG_IDLE;
		end else begin
			case (cfg_ff)
				pfb_pkg::PFB_CFG_IDLE: begin
					if (enter_config_edit_command) begin
						cfg_ff <= pfb_pkg::PFB_CFG_PROC;
					end
				end
				pfb_pkg::PFB_CFG_PROC: begin
					cfg_ff <= pfb_pkg::PFB_CFG_EDIT;
				end
				pfb_pkg::PFB_CFG_EDIT: begin
					if (exit_config_edit_command) begin
						cfg_ff <= pfb_pkg::PFB_CFG_IDLE;
					end
				end
				default: begin
					cfg_ff <= pfb_pkg::PFB_CFG_IDLE;
				end
			endcase
		end
	end
	assign config_edit_state = (cfg_ff == pfb_pkg::PFB_CFG_EDIT);
	// Full reset flag, cleared on leaving the edit state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_ff <= 1'b1;
		end else if (config_edit_state && exit_config_edit_command) begin
			por_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pack condition word
	// ----------------------------------------------------------------
	// fault summary
	assign nxt_pf_sum = (|stat_b_ff) || (|stat_c_ff) || stat_d_ff;
	always_comb begin
		nxt_pack = 16'h0000;
		nxt_pack[pfb_pkg::BW_SLEEP] = sleep_state;
		nxt_pack[pfb_pkg::BW_RSVD] = 1'b0;
		nxt_pack[pfb_pkg::BW_SDP] = sdp_ff;
		nxt_pack[pfb_pkg::BW_PF] = nxt_pf_sum;
		nxt_pack[pfb_pkg::BW_SS] = safety_fault_active;
		nxt_pack[pfb_pkg::BW_FUSE] = fuse_smp_ff;
		nxt_pack[pfb_pkg::BW_SEC_LSB +: 2] = security_state;
		nxt_pack[7:4] = {1'b0, low_flags};
		nxt_pack[pfb_pkg::BW_POR] = por_ff;
		nxt_pack[2] = sleep_allowed;
		nxt_pack[1] = soft_charge_state;
		nxt_pack[pfb_pkg::BW_CFG] = config_edit_state;
	end
	// Registered pack word; its summary bit doubles as the edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pack_ff <= 16'h0000;
		end else begin
			pack_ff <= nxt_pack;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status (write one to clear, set wins) and mask
	// ----------------------------------------------------------------
	always_comb begin
		nxt_int_ev = 3'h0;
		nxt_int_ev[pfb_pkg::IRQ_PF] = nxt_pf_sum && !pack_ff[pfb_pkg::BW_PF];
		nxt_int_ev[pfb_pkg::IRQ_ALERT] = |(nxt_alert_c & ~alert_c_ff);
		nxt_int_ev[pfb_pkg::IRQ_SHUT] = nxt_pack[pfb_pkg::BW_SDP] &&
			!pack_ff[pfb_pkg::BW_SDP];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_ff <= pfb_pkg::IRQ_RST;
		end else if (wr_acc && paddr == pfb_pkg::OFS_INT_STAT) begin
			int_stat_ff <= (int_stat_ff & ~pwdata[2:0]) | nxt_int_ev;
		end else begin
			int_stat_ff <= int_stat_ff | nxt_int_ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask_ff <= pfb_pkg::IRQ_RST;
		end else if (wr_acc && paddr == pfb_pkg::OFS_INT_MASK) begin
			int_mask_ff <= pwdata[2:0];
		end
	end
	assign irq = |(int_stat_ff & int_mask_ff);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_enter_cmd;
		enter_config_edit_command && cfg_ff == pfb_pkg::PFB_CFG_IDLE;
	endsequence
	sequence s_edit_open;
		!config_edit_state ##1 config_edit_state;
	endsequence
	a_short_latch_hold: assert property (
		stat_b_cond[7] && en_ff[7] |=> stat_b_ff[7] [*3])
		else $error("short circuit fault not latched");
	a_imbalance_rest: assert property (
		stat_b_cond[3] && en_ff[3] |=> stat_b_ff[3])
		else $error("rest imbalance fault missed");
	a_protector_fail: assert property (
		stat_b_cond[2] && en_ff[2] |=> stat_b_ff[2])
		else $error("protector fault missed");
	a_alert_c_resv: assert property (
		(alert_c_ff & ~pfb_pkg::MSK_ALRT_C) == 8'h00)
		else $error("alert C reserved bit set");
	a_forced_fail_set: assert property (
		host_forced_fail && en_ff[15] |=> ##1 pack_ff[pfb_pkg::BW_PF])
		else $error("forced fail not summarised");
	a_disabled_quiet: assert property (
		stat_b_ff == 8'h00 && en_ff[7:0] == 8'h00 |=> stat_b_ff == 8'h00)
		else $error("disabled condition set a flag");
	a_sleep_mirror: assert property (
		pack_ff[pfb_pkg::BW_SLEEP] == $past(sleep_state))
		else $error("sleep bit wrong");
	a_shutdown_cmd: assert property (
		shutdown_cmd |=> ##1 pack_ff[pfb_pkg::BW_SDP])
		else $error("shutdown pending not set");
	a_pf_summary: assert property (
		stat_d_ff |=> pack_ff[pfb_pkg::BW_PF])
		else $error("fault summary not set");
	a_safety_bit: assert property (
		pack_ff[pfb_pkg::BW_SS] == $past(safety_fault_active))
		else $error("safety bit wrong");
	a_pack_resv: assert property (
		!pack_ff[pfb_pkg::BW_RSVD])
		else $error("pack reserved bit set");
	a_cfg_enter: assert property (
		s_enter_cmd |=> s_edit_open)
		else $error("edit state timing wrong");
	a_read_clean: assert property (
		rd_set && stat_b_cond == 8'h00 |=> $stable(stat_b_ff))
		else $error("read changed a flag");

endmodule // pfb_flag_bank

/* design/pfb_pkg.sv */
// Register map, field layout and timing constants of the fail flag bank
package pfb_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB bus
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STAT_B = 8'h00;
	localparam logic [7:0] OFS_ALRT_C = 8'h04;
	localparam logic [7:0] OFS_STAT_C = 8'h08;
	localparam logic [7:0] OFS_ALRT_D = 8'h0c;
	localparam logic [7:0] OFS_STAT_D = 8'h10;
	localparam logic [7:0] OFS_PACK = 8'h14;
	localparam logic [7:0] OFS_PF_EN = 8'h18;
	localparam logic [7:0] OFS_INT_STAT = 8'h1c;
	localparam logic [7:0] OFS_INT_MASK = 8'h20;

	// ----------------------------------------------------------------
	// Implemented bits of each flag register
	// ----------------------------------------------------------------
	localparam logic [7:0] MSK_STAT_B = 8'h9f;
	localparam logic [7:0] MSK_ALRT_C = 8'h78;
	localparam logic [7:0] MSK_STAT_C = 8'hff;
	localparam logic [7:0] MSK_D = 8'h01;

	// Enable word layout and reset value
	localparam int EN_B_LSB = 0;
	localparam int EN_C_LSB = 8;
	localparam int EN_D_BIT = 16;
	localparam logic [16:0] EN_RST = 17'h1_ffff;

	// ----------------------------------------------------------------
	// Pack condition word bit positions
	// ----------------------------------------------------------------
	localparam int BW_SLEEP = 15;
	localparam int BW_RSVD = 14;
	localparam int BW_SDP = 13;
	localparam int BW_PF = 12;
	localparam int BW_SS = 11;
	localparam int BW_FUSE = 10;
	localparam int BW_SEC_LSB = 8;
	localparam int BW_POR = 3;
	localparam int BW_CFG = 0;

	// Security state encodings
	localparam logic [1:0] SEC_UNINIT = 2'h0;
	localparam logic [1:0] SEC_FULL = 2'h1;
	localparam logic [1:0] SEC_UNSEALED = 2'h2;
	localparam logic [1:0] SEC_SEALED = 2'h3;

	// Interrupt status bit positions
	localparam int IRQ_PF = 0;
	localparam int IRQ_ALERT = 1;
	localparam int IRQ_SHUT = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// ----------------------------------------------------------------
	// Timing: one second at the pclk rate
	// ----------------------------------------------------------------
	localparam int SEC_PERIOD_US = 1000000;
	localparam int CLK_MHZ = 200;
	localparam int SEC_CYC = SEC_PERIOD_US * CLK_MHZ;

	// Configuration edit sequencing
	typedef enum logic [1:0] {
		PFB_CFG_IDLE = 2'b00,
		PFB_CFG_PROC = 2'b01,
		PFB_CFG_EDIT = 2'b10
	} pfb_cfg_t;

endpackage

/* tb/pfb_flag_bank_tb.sv */
// Self-checking testbench of the permanent fail flag bank over APB
`timescale 1ns/1ps

module pfb_flag_bank_tb;
	localparam int SEC = 64;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] stat_b_cond = 8'h00;
	logic [7:0] alert_c_cond = 8'h00;
	logic [7:0] stat_c_cond = 8'h00;
	logic alert_d_cond = 1'b0;
	logic stat_d_cond = 1'b0;
	logic host_forced_fail = 1'b0;
	logic safety_fault_active = 1'b0;
	logic sleep_state = 1'b0;
	logic shutdown_cmd = 1'b0;
	logic shutdown_pin = 1'b0;
	logic fuse_pin = 1'b0;
	logic [1:0] security_state = 2'h0;
	logic [6:4] low_flags = 3'h0;
	logic sleep_allowed = 1'b0;
	logic soft_charge_state = 1'b0;
	logic enter_cmd = 1'b0;
	logic exit_cmd = 1'b0;
	logic config_edit_state;
	logic irq;
	logic e_sd = 1'b0;
	logic e_pf = 1'b0;
	logic e_fuse = 1'b0;
	logic e_por = 1'b1;
	logic e_cfg = 1'b0;
	int miscompares = 0;
	int n_tests = 0;

	// Clock at 200 MHz
	always #2.5 pclk = ~pclk;

	pfb_flag_bank #(.SEC_CYC(SEC)) i_pfb_flag_bank (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stat_b_cond(stat_b_cond),
		.alert_c_cond(alert_c_cond), .stat_c_cond(stat_c_cond),
		.alert_d_cond(alert_d_cond), .stat_d_cond(stat_d_cond),
		.host_forced_fail(host_forced_fail),
		.safety_fault_active(safety_fault_active),
		.sleep_state(sleep_state), .shutdown_cmd(shutdown_cmd),
		.shutdown_pin(shutdown_pin), .fuse_pin(fuse_pin),
		.security_state(security_state), .low_flags(low_flags),
		.sleep_allowed(sleep_allowed),
		.soft_charge_state(soft_charge_state),
		.enter_config_edit_command(enter_cmd),
		.exit_config_edit_command(exit_cmd),
		.config_edit_state(config_edit_state), .irq(irq)
	);

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	// Pack word expected from the driven levels and tracked events
	function automatic logic [31:0] pack_exp();
		return {16'h0000, sleep_state, 1'b0, e_sd, e_pf, safety_fault_active,
			e_fuse, security_state, 1'b0, low_flags, e_por, sleep_allowed,
			soft_charge_state, e_cfg};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
		chk("write error", {31'h0, err}, 32'h0000_0000);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
		input string nm);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		chk(nm, rd, exp);
		chk("read error", {31'h0, err}, 32'h0000_0000);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge pclk);
		miscompares++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic err;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(pfb_pkg::OFS_STAT_B, 32'h0000_0000, "status b");
		rdc(pfb_pkg::OFS_ALRT_C, 32'h0000_0000, "alert c");
		rdc(pfb_pkg::OFS_STAT_C, 32'h0000_0000, "status c");
		rdc(pfb_pkg::OFS_ALRT_D, 32'h0000_0000, "alert d");
		rdc(pfb_pkg::OFS_STAT_D, 32'h0000_0000, "status d");
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "pack word");
		rdc(pfb_pkg::OFS_PF_EN, 32'h0001_ffff, "enables");
		rdc(pfb_pkg::OFS_INT_STAT, 32'h0000_0000, "int status");
		apb(1'b0, 8'h24, 32'h0000_0000, rd, err);
		chk("unmapped error", {31'h0, err}, 32'h0000_0001);
		$display("test reset done");
		// Edit mode: disable every condition and show none latches
		enter_cmd <= 1'b1;
		@(posedge pclk);
		enter_cmd <= 1'b0;
		repeat (4) @(posedge pclk);
		e_cfg = 1'b1;
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "edit bit");
		chk("edit state", {31'h0, config_edit_state}, 32'h0000_0001);
		wr(pfb_pkg::OFS_PF_EN, 32'h0000_0000);
		stat_b_cond <= 8'hff;
		alert_c_cond <= 8'hff;
		stat_c_cond <= 8'hff;
		alert_d_cond <= 1'b1;
		stat_d_cond <= 1'b1;
		host_forced_fail <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc(pfb_pkg::OFS_STAT_B, 32'h0000_0000, "off status b");
		rdc(pfb_pkg::OFS_ALRT_C, 32'h0000_0000, "off alert c");
		rdc(pfb_pkg::OFS_STAT_C, 32'h0000_0000, "off status c");
		rdc(pfb_pkg::OFS_ALRT_D, 32'h0000_0000, "off alert d");
		rdc(pfb_pkg::OFS_STAT_D, 32'h0000_0000, "off status d");
		stat_b_cond <= 8'h00;
		alert_c_cond <= 8'h00;
		stat_c_cond <= 8'h00;
		alert_d_cond <= 1'b0;
		stat_d_cond <= 1'b0;
		host_forced_fail <= 1'b0;
		wr(pfb_pkg::OFS_PF_EN, 32'h0001_ffff);
		exit_cmd <= 1'b1;
		@(posedge pclk);
		exit_cmd <= 1'b0;
		repeat (4) @(posedge pclk);
		e_cfg = 1'b0;
		e_por = 1'b0;
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "edit exit");
		chk("edit closed", {31'h0, config_edit_state}, 32'h0000_0000);
		wr(pfb_pkg::OFS_PF_EN, 32'h0000_0000);
		rdc(pfb_pkg::OFS_PF_EN, 32'h0001_ffff, "locked enables");
		$display("test edit done");
		// Level bits of the pack word, every security code
		sleep_state <= 1'b1;
		safety_fault_active <= 1'b1;
		low_flags <= 3'h5;
		sleep_allowed <= 1'b1;
		soft_charge_state <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			security_state <= 2'(i);
			repeat (3) @(posedge pclk);
			rdc(pfb_pkg::OFS_PACK, pack_exp(), "pack levels");
		end
		sleep_state <= 1'b0;
		safety_fault_active <= 1'b0;
		repeat (3) @(posedge pclk);
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "pack low");
		$display("test levels done");
		// Faults latch, alerts follow, reads leave flags alone
		wr(pfb_pkg::OFS_STAT_B, 32'h0000_00ff);
		stat_b_cond <= 8'hff;
		alert_c_cond <= 8'hff;
		stat_c_cond <= 8'h7f;
		host_forced_fail <= 1'b1;
		alert_d_cond <= 1'b1;
		stat_d_cond <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc(pfb_pkg::OFS_ALRT_C, 32'h0000_0078, "alert c set");
		rdc(pfb_pkg::OFS_ALRT_D, 32'h0000_0001, "alert d set");
		stat_b_cond <= 8'h00;
		alert_c_cond <= 8'h00;
		stat_c_cond <= 8'h00;
		host_forced_fail <= 1'b0;
		alert_d_cond <= 1'b0;
		stat_d_cond <= 1'b0;
		repeat (4) @(posedge pclk);
		e_pf = 1'b1;
		rdc(pfb_pkg::OFS_STAT_B, 32'h0000_009f, "status b set");
		rdc(pfb_pkg::OFS_STAT_B, 32'h0000_009f, "status b again");
		rdc(pfb_pkg::OFS_STAT_C, 32'h0000_00ff, "status c set");
		rdc(pfb_pkg::OFS_STAT_D, 32'h0000_0001, "status d set");
		rdc(pfb_pkg::OFS_ALRT_C, 32'h0000_0000, "alert c gone");
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "pack fault");
		rdc(pfb_pkg::OFS_INT_STAT, 32'h0000_0003, "int events");
		chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		wr(pfb_pkg::OFS_INT_MASK, 32'h0000_0001);
		@(posedge pclk);
		chk("irq on", {31'h0, irq}, 32'h0000_0001);
		wr(pfb_pkg::OFS_INT_STAT, 32'h0000_0001);
		@(posedge pclk);
		chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
		rdc(pfb_pkg::OFS_INT_STAT, 32'h0000_0002, "int left");
		$display("test faults done");
		// Shutdown command and sampled protector pin
		wr(pfb_pkg::OFS_INT_MASK, 32'h0000_0004);
		shutdown_cmd <= 1'b1;
		@(posedge pclk);
		shutdown_cmd <= 1'b0;
		repeat (4) @(posedge pclk);
		e_sd = 1'b1;
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "shutdown");
		chk("irq shutdown", {31'h0, irq}, 32'h0000_0001);
		fuse_pin <= 1'b1;
		repeat (3 * SEC) @(posedge pclk);
		e_fuse = 1'b1;
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "fuse high");
		fuse_pin <= 1'b0;
		repeat (3 * SEC) @(posedge pclk);
		e_fuse = 1'b0;
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "fuse low");
		$display("test pins done");
		// Reset in mid-run clears latches; shutdown pin held a second
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		e_sd = 1'b0;
		e_pf = 1'b0;
		e_por = 1'b1;
		rdc(pfb_pkg::OFS_STAT_B, 32'h0000_0000, "status b reset");
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "pack reset");
		chk("irq reset", {31'h0, irq}, 32'h0000_0000);
		shutdown_pin <= 1'b1;
		repeat (SEC / 2) @(posedge pclk);
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "pin early");
		repeat (SEC) @(posedge pclk);
		e_sd = 1'b1;
		rdc(pfb_pkg::OFS_PACK, pack_exp(), "pin held");
		shutdown_pin <= 1'b0;
		$display("test mid reset done");
		end_sim();
	end
endmodule // pfb_flag_bank_tb
